// File: seg_map_pkg.sv
// Purpose: shared constants and carrier types of the segment map context unit
// Assumes: 24-bit logical address, 21-bit physical address, 512-byte pages
// Notes:   offsets, field positions and reset values live here only
package seg_map_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADDR_W     = 24;
    localparam int PHYS_W     = 21;
    localparam int OFF_W      = 9;
    localparam int PAGE_W     = 8;
    localparam int SEG_W      = 7;
    localparam int MAP_W      = 12;
    localparam int CTX_W      = 2;
    localparam int CODE_W     = 4;

    // ************************************************************
    // field positions in the logical address
    // ************************************************************
    localparam int SEG_LSB    = 17;
    localparam int PAGE_LSB   = 9;
    localparam int RAM_SEL_BIT = 14;
    localparam int MAP_SEL_BIT = 15;
    localparam int LIM_SEL_BIT = 3;
    localparam int ROM_HI_BIT = 13;

    // ************************************************************
    // limit register control field
    // ************************************************************
    localparam int CTL_LSB    = 8;
    localparam logic [3:0] CODE_RO_STACK = 4'h4;
    localparam logic [3:0] CODE_RO       = 4'h5;
    localparam logic [3:0] CODE_RW_STACK = 4'h6;
    localparam logic [3:0] CODE_RW       = 4'h7;
    localparam logic [3:0] CODE_IO       = 4'h9;
    localparam logic [3:0] CODE_ABSENT   = 4'hc;
    localparam logic [3:0] CODE_SPECIAL  = 4'hf;
    localparam logic [8:0] STACK_FLOOR   = 9'h0ff;

    // ************************************************************
    // strobe addresses in i/o space
    // ************************************************************
    localparam logic [20:0] ADR_CTX_LOW_CLR  = 21'h00e008;
    localparam logic [20:0] ADR_CTX_LOW_SET  = 21'h00e00a;
    localparam logic [20:0] ADR_CTX_HIGH_CLR = 21'h00e00c;
    localparam logic [20:0] ADR_CTX_HIGH_SET = 21'h00e00e;
    localparam logic [20:0] ADR_SETUP_ENTRY  = 21'h00e010;
    localparam logic [20:0] ADR_SETUP_EXIT   = 21'h00e012;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic       RST_SETUP = 1'b1;
    localparam logic [1:0] RST_CTX   = 2'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              supervisor;
        logic [ADDR_W-1:0] addr;
        logic [MAP_W-1:0]  wdata;
    } cpu_req_s;

    typedef struct packed {
        logic              ack;
        logic              err;
        logic [PHYS_W-1:0] phys;
        logic [CODE_W-1:0] code;
        logic              rom_sel;
        logic              map_sel;
        logic [MAP_W-1:0]  rdata;
    } cpu_resp_s;

endpackage : seg_map_pkg

// File: seg_map_regs.sv
// Purpose: origin and limit register arrays of all contexts
// Assumes: one write port, two asynchronous read ports
// Notes:   contents are not reset and stay undefined until loaded
`timescale 1ns/1ps
module seg_map_regs #(
    parameter int CTX_W = 2,
    parameter int SEG_W = 7,
    parameter int MAP_W = 12
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_we,
    input  wire logic                   i_we_limit,
    input  wire logic [CTX_W+SEG_W-1:0] i_widx,
    input  wire logic [MAP_W-1:0]       i_wdata,
    input  wire logic [CTX_W+SEG_W-1:0] i_tidx,
    output logic      [MAP_W-1:0]       o_torigin,
    output logic      [MAP_W-1:0]       o_tlimit,
    output logic      [MAP_W-1:0]       o_morigin,
    output logic      [MAP_W-1:0]       o_mlimit
);

    localparam int DEPTH = 2 ** (CTX_W + SEG_W);

    // four context sets of 128 origin/limit pairs
    logic [MAP_W-1:0] origin_mem [DEPTH];
    logic [MAP_W-1:0] limit_mem  [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we && !i_we_limit) begin
            origin_mem[i_widx] <= i_wdata;
        end
        if (i_we && i_we_limit) begin
            limit_mem[i_widx] <= i_wdata;
        end
    end

    assign o_torigin = origin_mem[i_tidx];
    assign o_tlimit  = limit_mem[i_tidx];
    assign o_morigin = origin_mem[i_widx];
    assign o_mlimit  = limit_mem[i_widx];

endmodule : seg_map_regs

// File: seg_map_unit.sv
// Purpose: segment translation, protection, setup mode and context select
// Assumes: one request per cycle, answered at the next edge
// Notes:   map registers are reached only through unmapped special i/o
//
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// R1: 1024 twelve-bit map registers, four contexts of 128 origin/limit pairs.
// R2: map registers are reached only through special i/o accesses.
// R3: origin holds the segment start as a count of 512-byte pages.
// R4: normal segment limit is two's complement; 00 max, ff one page.
// R5: stack segment grows down from the top; 00 one page, ff full.
// R6: control bits 11..8 decode access type; other codes are invalid.
// R7: map contents undefined after reset; writes only accepted in setup mode.
// R8: setup mode at power-on; software re-enters it at address 00e010.
// R9: in setup, bit 14 low selects boot rom and map registers.
// R10: in setup mode the access-type output is forced to 1111.
// R11: in setup, bit 14 high accesses are translated as normal.
// R12: special i/o takes segment from bits 23..17 or rom from 13..1; the code takes rom from bits 13..0.
// R13: software puts the segment number in top bits, looking shifted left.
// R14: two select bits pick one of four independent contexts.
// R15: supervisor accesses always use context 0.
// R16: context change takes effect on later accesses, or after supervisor exit.
// R17: reads or writes to four strobe addresses set or clear select bits.
// R18: operating system loads all segments, changes maps only in supervisor.
// R19: physical page is origin plus page displacement; offset passes through.
// R20: limit has four control bits above an eight-bit page count.
// R21: limit violation aborts the access and signals an error.
// R22: a separate strobe address leaves setup mode.
// R23: both context select bits clear at reset.
`timescale 1ns/1ps
module seg_map_unit (
    input  wire logic                  I_SYS_CLK,
    input  wire logic                  I_RESETN,
    input  wire seg_map_pkg::cpu_req_s I_CPU,
    output seg_map_pkg::cpu_resp_s     O_RESP,
    output logic                       O_SETUP,
    output logic [1:0]                 O_CONTEXT
);
    import seg_map_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic             setup;
        logic [CTX_W-1:0] ctx;
        cpu_resp_s        resp;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    // ************************************************************
    // address fields
    // ************************************************************
    logic [SEG_W-1:0]       seg;
    logic [PAGE_W-1:0]      page;
    logic [OFF_W-1:0]       offset;
    logic [CTX_W-1:0]       eff_ctx;
    logic [CTX_W+SEG_W-1:0] tidx;
    logic [CTX_W+SEG_W-1:0] midx;
    logic [MAP_W-1:0]       t_origin;
    logic [MAP_W-1:0]       t_limit;
    logic [MAP_W-1:0]       m_origin;
    logic [MAP_W-1:0]       m_limit;
    logic [CODE_W-1:0]      ctl;
    logic [PAGE_W-1:0]      lim_pages;
    logic [MAP_W-1:0]       phys_page;
    logic [8:0]             lim_sum;
    logic                   in_limit;
    logic                   unmapped;
    logic                   map_access;
    logic                   map_we;
    logic                   map_err;
    logic [PHYS_W-1:0]      mapped_phys;
    logic                   io_hit;

    assign seg    = I_CPU.addr[SEG_LSB +: SEG_W];    // [R12]
    assign page   = I_CPU.addr[PAGE_LSB +: PAGE_W];
    assign offset = I_CPU.addr[OFF_W-1:0];

    // supervisor accesses run under the system map [R15]
    assign eff_ctx = I_CPU.supervisor ? RST_CTX : state_r.ctx;
    assign tidx    = {eff_ctx, seg};                 // [R14]
    // loading goes by the select bits so the system can fill every set
    assign midx    = {state_r.ctx, seg};

    // ************************************************************
    // decoding helpers
    // ************************************************************
    function automatic logic code_valid(input logic [3:0] c);
        code_valid = (c == CODE_RO_STACK) || (c == CODE_RO) ||
                     (c == CODE_RW_STACK) || (c == CODE_RW) ||
                     (c == CODE_IO) || (c == CODE_ABSENT) ||
                     (c == CODE_SPECIAL);
    endfunction : code_valid

    function automatic logic code_stack(input logic [3:0] c);
        code_stack = (c == CODE_RO_STACK) || (c == CODE_RW_STACK);
    endfunction : code_stack

    function automatic logic code_read_only(input logic [3:0] c);
        code_read_only = (c == CODE_RO_STACK) || (c == CODE_RO);
    endfunction : code_read_only

    // ************************************************************
    // map registers
    // ************************************************************
    seg_map_regs #(
        .CTX_W (CTX_W),
        .SEG_W (SEG_W),
        .MAP_W (MAP_W)
    ) u_regs (                                       // [R1]
        .i_clk      (I_SYS_CLK),
        .i_we       (map_we),
        .i_we_limit (I_CPU.addr[LIM_SEL_BIT]),
        .i_widx     (midx),
        .i_wdata    (I_CPU.wdata),
        .i_tidx     (tidx),
        .o_torigin  (t_origin),
        .o_tlimit   (t_limit),
        .o_morigin  (m_origin),
        .o_mlimit   (m_limit)
    );

    // ************************************************************
    // translation and limit check
    // ************************************************************
    assign ctl       = t_limit[CTL_LSB +: CODE_W];   // [R20]
    assign lim_pages = t_limit[PAGE_W-1:0];          // [R20]
    // origin counts whole 512-byte pages [R3]
    assign phys_page = t_origin + {{(MAP_W-PAGE_W){1'b0}}, page};  // [R19]
    assign mapped_phys = {phys_page, offset};        // [R19]
    assign lim_sum   = {1'b0, page} + {1'b0, lim_pages};

    // normal: page + limit must not carry past 255 [R4]
    // stack: page + limit must reach 255, counted down from the top [R5]
    assign in_limit = code_stack(ctl) ? (lim_sum >= STACK_FLOOR) : !lim_sum[8];

    // unmapped special i/o: bit 14 low, in setup or in a special segment [R9] [R12]
    assign unmapped = !I_CPU.addr[RAM_SEL_BIT] &&
                      (state_r.setup || (ctl == CODE_SPECIAL));
    assign map_access = unmapped && I_CPU.addr[MAP_SEL_BIT];       // [R2]

    // writes outside setup mode are refused [R7]
    assign map_we = I_CPU.valid && map_access && I_CPU.write && state_r.setup;

    // invalid codes are faulted rather than left to chance [R6]
    assign map_err = !in_limit || !code_valid(ctl) || (ctl == CODE_ABSENT) ||
                     (I_CPU.write && code_read_only(ctl));          // [R21]

    assign io_hit = I_CPU.valid && !unmapped && !map_err && (ctl == CODE_IO);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        state_nxt.resp.ack = 1'b0;
        state_nxt.resp.err = 1'b0;
        if (I_CPU.valid) begin
            state_nxt.resp.ack     = 1'b1;
            state_nxt.resp.rom_sel = 1'b0;
            state_nxt.resp.map_sel = 1'b0;
            state_nxt.resp.rdata   = '0;
            if (unmapped) begin
                state_nxt.resp.code = CODE_SPECIAL;
                state_nxt.resp.phys = '0;
                if (I_CPU.addr[MAP_SEL_BIT]) begin
                    state_nxt.resp.map_sel = 1'b1;   // [R2]
                    state_nxt.resp.rdata   = I_CPU.addr[LIM_SEL_BIT] ? m_limit : m_origin;
                    state_nxt.resp.err     = I_CPU.write && !state_r.setup;  // [R7]
                end else begin
                    // boot rom byte address from bits 13..0, never translated [R9] [R12]
                    state_nxt.resp.rom_sel = 1'b1;
                    state_nxt.resp.phys    = {{(PHYS_W-ROM_HI_BIT-1){1'b0}},
                                              I_CPU.addr[ROM_HI_BIT:0]};
                end
            end else begin
                // bit 14 high in setup still goes through the map [R11]
                state_nxt.resp.phys = mapped_phys;
                state_nxt.resp.err  = map_err;       // [R21]
                // setup forces the special code whatever is stored [R10]
                state_nxt.resp.code = state_r.setup ? CODE_SPECIAL : ctl;
            end
        end
        // strobes act on any read or write [R17]
        if (io_hit) begin
            if (mapped_phys == ADR_CTX_LOW_CLR) begin
                state_nxt.ctx[0] = 1'b0;             // [R17]
            end else if (mapped_phys == ADR_CTX_LOW_SET) begin
                state_nxt.ctx[0] = 1'b1;             // [R17]
            end else if (mapped_phys == ADR_CTX_HIGH_CLR) begin
                state_nxt.ctx[1] = 1'b0;             // [R17]
            end else if (mapped_phys == ADR_CTX_HIGH_SET) begin
                state_nxt.ctx[1] = 1'b1;             // [R17]
            end else if (mapped_phys == ADR_SETUP_ENTRY) begin
                state_nxt.setup = 1'b1;              // [R8]
            end else if (mapped_phys == ADR_SETUP_EXIT) begin
                state_nxt.setup = 1'b0;              // [R22]
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // the new context reaches only later accesses; supervisor still
    // maps to context 0 until it is left [R16]
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            state_r       <= '0;
            state_r.setup <= RST_SETUP;              // [R8]
            state_r.ctx   <= RST_CTX;                // [R23]
        end else begin
            state_r <= state_nxt;
        end
    end

    assign O_RESP    = state_r.resp;
    assign O_SETUP   = state_r.setup;
    assign O_CONTEXT = state_r.ctx;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);

    reset_state_a: assert property (!$past(I_RESETN) |-> O_SETUP && O_CONTEXT == 2'h0) // [R23]
        else $error("setup or context wrong after reset");

    setup_code_a: assert property (I_CPU.valid && state_r.setup |=>           // [R10]
        O_RESP.ack && O_RESP.code == CODE_SPECIAL)
        else $error("access code not forced in setup");

    setup_write_a: assert property (I_CPU.valid && I_CPU.write && map_access  // [R7]
        && !state_r.setup |-> !map_we ##1 O_RESP.err)
        else $error("map write accepted outside setup");

    sup_context_a: assert property (I_CPU.valid && I_CPU.supervisor          // [R15]
        |-> tidx[CTX_W+SEG_W-1:SEG_W] == 2'h0)
        else $error("supervisor access not in context 0");

    offset_pass_a: assert property (I_CPU.valid && !unmapped |=>             // [R19]
        O_RESP.phys[OFF_W-1:0] == $past(offset))
        else $error("page offset changed by translation");

    limit_abort_a: assert property (I_CPU.valid && !unmapped && !in_limit    // [R21]
        |=> O_RESP.ack && O_RESP.err)
        else $error("limit violation not aborted");

    absent_seg_a: assert property (I_CPU.valid && !unmapped                  // [R6]
        && ctl == CODE_ABSENT |=> O_RESP.err)
        else $error("absent segment not faulted");

    ctx_strobe_a: assert property (io_hit && mapped_phys == ADR_CTX_HIGH_SET  // [R17]
        |=> O_CONTEXT[1] ##1 O_CONTEXT[1] || $past(io_hit))
        else $error("high select bit not set by strobe");

    setup_entry_a: assert property (io_hit && mapped_phys == ADR_SETUP_ENTRY  // [R8]
        |=> O_SETUP)
        else $error("setup not entered by strobe");

    rom_path_a: assert property (I_CPU.valid && state_r.setup                // [R9]
        && !I_CPU.addr[RAM_SEL_BIT] && !I_CPU.addr[MAP_SEL_BIT]
        |=> O_RESP.rom_sel && !O_RESP.err)
        else $error("setup rom access not unmapped");

    ack_once_a: assert property (!I_CPU.valid |=> !O_RESP.ack) // [R21]
        else $error("answer without request");

    ack_follow_a: assert property (I_CPU.valid |=> O_RESP.ack) // [R21]
        else $error("request not answered");

    map_select_a: assert property (I_CPU.valid && map_access |=> // [R2]
        O_RESP.map_sel && O_RESP.code == CODE_SPECIAL)
        else $error("map access not flagged");

    rom_select_a: assert property (I_CPU.valid && unmapped // [R12]
        && !I_CPU.addr[MAP_SEL_BIT] |=> O_RESP.rom_sel && !O_RESP.map_sel)
        else $error("rom access not flagged");

    page_add_a: assert property (I_CPU.valid && !unmapped |=> // [R19] [R3]
        O_RESP.phys[PHYS_W-1:OFF_W] == $past(t_origin) + {4'h0, $past(page)})
        else $error("page not origin plus displacement");

    normal_over_a: assert property (I_CPU.valid && !unmapped && ctl == CODE_RW // [R4]
        && 9'(page) + 9'(lim_pages) > 9'h0ff |=> O_RESP.err)
        else $error("normal overrun not faulted");

    normal_fit_a: assert property (I_CPU.valid && !unmapped && ctl == CODE_RW // [R4]
        && 9'(page) + 9'(lim_pages) < 9'h100 |=> !O_RESP.err)
        else $error("normal access in limit faulted");

    stack_under_a: assert property (I_CPU.valid && !unmapped && ctl == CODE_RW_STACK // [R5]
        && 9'(page) + 9'(lim_pages) < 9'h0ff |=> O_RESP.err)
        else $error("stack underrun not faulted");

    stack_fit_a: assert property (I_CPU.valid && !unmapped && ctl == CODE_RW_STACK // [R5]
        && 9'(page) + 9'(lim_pages) >= 9'h0ff |=> !O_RESP.err)
        else $error("stack access in limit faulted");

    ro_write_a: assert property (I_CPU.valid && !unmapped && I_CPU.write // [R6]
        && ctl == CODE_RO |=> O_RESP.err)
        else $error("read-only write accepted");

    bad_code_a: assert property (I_CPU.valid && !unmapped && !code_valid(ctl) // [R6]
        |=> O_RESP.err)
        else $error("invalid code not faulted");

    code_pass_a: assert property (I_CPU.valid && !unmapped && !state_r.setup // [R20]
        |=> O_RESP.code == $past(ctl))
        else $error("access code not from limit");

    low_set_a: assert property (io_hit && mapped_phys == ADR_CTX_LOW_SET // [R17]
        |=> O_CONTEXT[0])
        else $error("low select bit not set");

    low_clear_a: assert property (io_hit && mapped_phys == ADR_CTX_LOW_CLR // [R17]
        |=> !O_CONTEXT[0])
        else $error("low select bit not cleared");

    high_clear_a: assert property (io_hit && mapped_phys == ADR_CTX_HIGH_CLR // [R17]
        |=> !O_CONTEXT[1])
        else $error("high select bit not cleared");

    setup_exit_a: assert property (io_hit && mapped_phys == ADR_SETUP_EXIT // [R22]
        |=> !O_SETUP)
        else $error("setup not left by strobe");

    ctx_hold_a: assert property (!io_hit |=> $stable(O_CONTEXT)) // [R17]
        else $error("select bits moved without strobe");

    setup_hold_a: assert property (!io_hit |=> $stable(O_SETUP)) // [R8]
        else $error("setup flag moved without strobe");

    resp_hold_a: assert property (!I_CPU.valid |=> $stable(O_RESP.phys) // [R19]
        && $stable(O_RESP.code) && $stable(O_RESP.rdata))
        else $error("answer changed without request");

endmodule : seg_map_unit

// File: host_cpu_model.sv
// Purpose: host processor model that issues requests to the segment map unit
// Assumes: one request per cycle, answer flopped at the edge that takes it
// Notes:   released address and data lines carry the inverse of the last value
`timescale 1ns/1ps
module host_cpu_model (
    input  wire logic                   i_clk,
    input  wire seg_map_pkg::cpu_resp_s i_resp,
    output seg_map_pkg::cpu_req_s       o_req
);
    import seg_map_pkg::*;

    // ****************************************************************
    // request driver
    // ****************************************************************
    initial o_req = '0;

    // segment number sits in the top seven bits, so it reads shifted left by one
    function automatic logic [23:0] map_addr(input logic [6:0] seg, input logic lim);
        return {seg, 3'b010, 10'h000, lim, 3'h0};
    endfunction : map_addr

    // valid stands one cycle only: holding it longer would be taken as a second request
    task automatic access(input logic wr, input logic sup, input logic [23:0] a,
                          input logic [11:0] wd, output cpu_resp_s r);
        @(posedge i_clk);
        o_req.valid      <= 1'b1;
        o_req.write      <= wr;
        o_req.supervisor <= sup;
        o_req.addr       <= a;
        o_req.wdata      <= wd;
        @(posedge i_clk);
        o_req.valid <= 1'b0;
        o_req.addr  <= ~a;
        o_req.wdata <= ~wd;
        #1;
        r = i_resp;
    endtask : access

endmodule : host_cpu_model

// File: segment_map_context_unit_tb.sv
// Purpose: self-checking bench of the segment map unit against an integer model
// Assumes: strobes reach the unit through segment 7e mapped as i/o space
// Notes:   segment 7f is special i/o so map reads work outside setup
`timescale 1ns/1ps
module segment_map_context_unit_tb;
    import seg_map_pkg::*;

    // ****************************************************************
    // signals and model state
    // ****************************************************************
    logic        i_sys_clk  = 1'b0;
    logic        i_resetn   = 1'b0;
    cpu_req_s    cpu_req;
    cpu_resp_s   resp;
    cpu_resp_s   r;
    logic        setup_flag;
    logic [1:0]  ctx_bits;
    int          num_errors = 0;
    int          tests_run  = 0;
    logic [31:0] rng        = 32'h0000aa16;
    int          orig [512];
    int          lim  [512];
    logic [3:0]  codes [13] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'h0, 4'h1, 4'h2, 4'h8,
                                4'ha, 4'hb, 4'hd, 4'he};

    seg_map_unit u_dut (
        .I_SYS_CLK (i_sys_clk),
        .I_RESETN  (i_resetn),
        .I_CPU     (cpu_req),
        .O_RESP    (resp),
        .O_SETUP   (setup_flag),
        .O_CONTEXT (ctx_bits)
    );

    host_cpu_model u_host (
        .i_clk  (i_sys_clk),
        .i_resp (resp),
        .o_req  (cpu_req)
    );

    always #4 i_sys_clk = ~i_sys_clk;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic acc(input logic wr, input logic sup, input logic [23:0] a,
                       input logic [11:0] wd);
        u_host.access(wr, sup, a, wd, r);
        check(24'(r.ack), 24'h000001);
    endtask : acc

    // page 20h keeps bit 14 high so strobes are translated in setup mode too
    task automatic strobe(input logic [8:0] off);
        acc(1'(xs()), 1'b1, {7'h7e, 8'h20, off}, 12'h000);
    endtask : strobe

    task automatic set_ctx(input logic [1:0] c);
        strobe(c[0] ? 9'h00a : 9'h008);
        strobe(c[1] ? 9'h00e : 9'h00c);
        check(24'(ctx_bits), 24'(c));
    endtask : set_ctx

    // only legal in setup mode; index is context * 128 + segment
    task automatic map_wr(input int idx, input logic l, input int v);
        acc(1'b1, 1'b1, u_host.map_addr(7'(idx % 128), l), 12'(v));
        if (l)
            lim[idx] = v;
        else
            orig[idx] = v;
        acc(1'b0, 1'b1, u_host.map_addr(7'(idx % 128), l), 12'h000);
        check(24'(r.rdata), 24'(v));
        check(24'(r.code), 24'h00000f);
        check(24'(r.map_sel), 24'h000001);
    endtask : map_wr

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        int c;
        int s;
        int pg;
        int off;
        int ix;
        int ec;
        int cnt;
        bit e;
        logic [23:0] a;
        logic wr;
        logic sup;
        repeat (20) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        check(24'(setup_flag), 24'h000001);
        check(24'(ctx_bits), 24'h000000);
        $display("test reset done");
        map_wr(126, 1'b0, 32'h050);
        map_wr(126, 1'b1, 32'h900);
        map_wr(127, 1'b0, 32'h000);
        map_wr(127, 1'b1, 32'hf00);
        map_wr(16, 1'b0, 32'h001);
        map_wr(16, 1'b1, 32'h700);
        for (c = 0; c < 4; c++) begin
            set_ctx(2'(c));
            for (s = 0; s < 16; s++) begin
                map_wr(c * 128 + s, 1'b0, int'(xs() % 4096));
                map_wr(c * 128 + s, 1'b1, int'(codes[xs() % 13]) * 256 + int'(xs() % 256));
            end
        end
        $display("test map load done");
        a = {7'(xs()), 1'(xs()), 2'b00, 14'(xs())};
        acc(1'b0, 1'b1, a, 12'h000);
        check(24'(r.rom_sel), 24'h000001);
        check(24'(r.phys), {10'h000, a[13:0]});
        off = int'(xs() % 512);
        acc(1'b0, 1'b1, {7'h10, 8'h20, 9'(off)}, 12'h000);
        check(24'(r.phys), {3'h0, 12'h021, 9'(off)});
        check(24'(r.code), 24'h00000f);
        strobe(9'h012);
        check(24'(setup_flag), 24'h000000);
        set_ctx(2'h0);
        acc(1'b1, 1'b1, u_host.map_addr(7'h7f, 1'b0), 12'habc);
        check(24'(r.err), 24'h000001);
        acc(1'b0, 1'b1, u_host.map_addr(7'h7f, 1'b0), 12'h000);
        check(24'(r.rdata), 24'h000000);
        acc(1'b0, 1'b1, {7'h10, 17'h00000}, 12'h000);
        check(24'(r.phys), 24'h000200);
        $display("test setup exit done");
        for (int i = 0; i < 300; i++) begin
            c = int'(xs() % 4);
            set_ctx(2'(c));
            sup = 1'(xs());
            wr = 1'(xs());
            s = int'(xs() % 16);
            pg = int'(xs() % 256);
            off = int'(xs() % 512);
            acc(wr, sup, {7'(s), 8'(pg), 9'(off)}, 12'(xs()));
            ix = (sup ? 0 : c) * 128 + s;
            ec = lim[ix] / 256;
            cnt = lim[ix] % 256;
            e = (ec == 4 || ec == 6) ? (pg + cnt < 255) :
                (ec == 5 || ec == 7) ? (pg + cnt >= 256) : 1'b1;
            e = e | (wr & (ec == 4 || ec == 5));
            check(24'(r.err), 24'(e));
            if (!e) begin
                check(24'(r.phys), 24'(((orig[ix] + pg) % 4096) * 512 + off));
                check(24'(r.code), 24'(ec));
            end
        end
        $display("test translation done");
        strobe(9'h010);
        check(24'(setup_flag), 24'h000001);
        $display("test setup entry done");
        test_done();
    end

    // a run well past the expected few thousand cycles means a hang
    initial begin
        repeat (10000) @(posedge i_sys_clk);
        num_errors++;
        test_done();
    end

endmodule : segment_map_context_unit_tb
